// [shared/phy_regs_pkg.sv]
// Constants, field layouts and carrier types for the PHY management register bank
package phy_regs_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int IDX_W = 5;                    // Register index width
    localparam int DATA_W = 16;                  // Register data width
    localparam int DEPTH = 32;                   // Index space size

    // ==========================================================
    // Register indices
    // ==========================================================
    localparam logic [4:0] IDX_PHY_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] IDX_PHY_BASIC_STATUS = 5'h01;
    localparam logic [4:0] IDX_PHY_IDENT_HIGH = 5'h02;
    localparam logic [4:0] IDX_PHY_IDENT_LOW = 5'h03;
    localparam logic [4:0] IDX_NEGOTIATION_ADVERTISE = 5'h04;
    localparam logic [4:0] IDX_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] IDX_NEGOTIATION_EXPANSION = 5'h06;
    localparam logic [4:0] IDX_MODE_CONTROL_STATUS = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_INDICATIONS = 5'h1B;
    localparam logic [4:0] IDX_PHY_IRQ_SOURCE = 5'h1D;
    localparam logic [4:0] IDX_PHY_IRQ_MASK = 5'h1E;
    localparam logic [4:0] IDX_PHY_SPECIAL_CONTROL = 5'h1F;

    // Per-index maps: decoded, software writable, kept across soft reset
    localparam logic [31:0] DECODED_MASK = 32'hE806_007F;
    localparam logic [31:0] WRITABLE_MASK = 32'hC806_0010;
    localparam logic [31:0] KEEP_MASK = 32'h0004_0000;

    // ==========================================================
    // Basic control fields
    // ==========================================================
    localparam int CTL_SOFT_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED_100 = 13;
    localparam int CTL_AN_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_AN_RESTART = 9;
    localparam int CTL_FULL_DUPLEX = 8;
    localparam int CTL_COL_TEST = 7;
    localparam logic [15:0] CTL_WRITE_MASK = 16'hFB80;   // Bits 10 and 6..0 reserved
    localparam logic [15:0] CTL_RESET = 16'h0000;        // Strap bits are merged in

    // ==========================================================
    // Basic status fields and other reset values
    // ==========================================================
    localparam logic [15:0] STS_CAPS = 16'h7809;          // Fixed ability bits
    localparam int STS_AN_DONE = 5;
    localparam int STS_LINK = 2;
    localparam logic [15:0] ADVERTISE_RESET = 16'h01E1;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 200;
    localparam int SOFT_RESET_NS = 1000;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int AN_TIME_MS = 1500;
    localparam int AN_CYCLES_DEF = AN_TIME_MS * CLK_MHZ * 1000;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic valid;                 // One-cycle command strobe
        logic write;                 // 1 = write, 0 = read
        logic [4:0] index;           // Register index
        logic [15:0] data;           // Write data
    } access_cmd_t;

    typedef struct packed {
        logic done;                  // One-cycle completion pulse
        logic [15:0] data;           // Read data, zero for writes
    } access_resp_t;

    typedef struct packed {
        logic loopback;
        logic power_down;
        logic speed_100;
        logic full_duplex;
        logic col_test;
        logic an_complete;
        logic soft_reset;
    } phy_mode_t;

    typedef enum logic [1:0] {AN_IDLE, AN_RUN, AN_DONE} an_state_t;

    // Reset value of a memory-held register
    function automatic logic [15:0] entry_reset(input int idx);
        entry_reset = (idx == int'(IDX_NEGOTIATION_ADVERTISE)) ? ADVERTISE_RESET : 16'h0000;
    endfunction

endpackage

// [hdl/phy_reg_store.sv]
// Small register store for the general PHY registers, registered read port
`timescale 1ns/1ps
`default_nettype none
module phy_reg_store #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 16,
    parameter logic [31:0] WRITABLE = 32'h0000_0000,
    parameter logic [31:0] KEEP = 32'h0000_0000
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Clear of entries not kept across soft reset
    input wire logic soft_clear,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_r
);
    import phy_regs_pkg::*;

    // ==========================================================
    // Storage
    // ==========================================================
    logic [WIDTH-1:0] mem_r [DEPTH];   // One word per index

    // One entry per index
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            // Hard reset, soft clear unless kept, write if writable
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    mem_r[gi] <= WIDTH'(entry_reset(gi));
                end else if (soft_clear && !KEEP[gi]) begin
                    mem_r[gi] <= WIDTH'(entry_reset(gi));
                end else if (wr_en && WRITABLE[gi] && (wr_addr == ($clog2(DEPTH))'(gi))) begin
                    mem_r[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

endmodule
`default_nettype wire

// [hdl/phy_basic_control_regs.sv]
// PHY management register bank reached through an indexed access port
//
// How it works
// - Registers reached only via access command/data
// - Decode indices 0-6, 17, 18, 27, 29-31
// - Control bit 15 starts self-clearing soft reset
// - Kept fields survive only soft reset
// - Control bit 14 selects loopback, resets zero
// - Bit 13 forces speed unless negotiation on
// - Bit 12 runs negotiation, overriding forced bits
// - Bit 11 enters power down, resets zero
// - Leaving power down renegotiates, sets status bit 5
// - Bit 9 restarts negotiation, self-clears
// - Bit 8 forces duplex unless negotiation on
// - Bit 7 enables collision test, resets zero
// - Speed and negotiation defaults from strap pin
// - Status bit 5 shows negotiation complete
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_regs #(
    parameter int AN_CYCLES = phy_regs_pkg::AN_CYCLES_DEF,
    parameter logic [15:0] IDENT_HIGH = 16'h1234,   // Arbitrary identifier value
    parameter logic [15:0] IDENT_LOW = 16'h5678     // Arbitrary identifier value
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Speed strap pin
    input wire logic speed_strap,
    // Indexed access port from the MAC side
    input wire phy_regs_pkg::access_cmd_t phy_access_command_reg,
    output phy_regs_pkg::access_resp_t access_resp_r,
    output logic busy_r,
    // Operating mode towards the PHY core
    output phy_regs_pkg::phy_mode_t mode_r
);
    import phy_regs_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [15:0] ctrl_r;                 // Basic control bits
    logic [15:0] ctrl_nxt;               // Next basic control bits
    logic [15:0] ctrl_default;           // Reset value with strap merged
    logic [15:0] srst_cnt_r;             // Soft reset duration counter
    logic [15:0] srst_cnt_nxt;
    logic srst_last;                     // Last cycle of soft reset
    an_state_t an_state_r;               // Negotiation state
    an_state_t an_state_nxt;
    logic [31:0] an_cnt_r;               // Negotiation duration counter
    logic [31:0] an_cnt_nxt;
    logic an_allowed;                    // Negotiation may run
    logic an_last;                       // Final negotiation cycle
    logic take;                          // Command accepted
    logic wr_ctrl;                       // Write to basic control
    logic srst_start;                    // Write that sets the reset bit
    logic mem_we;                        // Write to the register store
    logic pend_r;                        // Accepted command in stage one
    logic write_q_r;                     // Stage one is a write
    logic [4:0] idx_q_r;                 // Stage one index
    logic [15:0] mem_rd;                 // Store read data
    logic [15:0] status_word;            // Composed basic status
    logic [15:0] read_word;              // Selected read data
    logic busy_nxt;
    logic link_up;                       // Link indication
    phy_mode_t mode_nxt;

    // ==========================================================
    // Command acceptance and decode
    // ==========================================================
    // One command every other cycle; a strobe while busy is dropped
    assign take = phy_access_command_reg.valid && !busy_r;
    assign wr_ctrl = take && phy_access_command_reg.write
        && (phy_access_command_reg.index == IDX_PHY_BASIC_CONTROL);
    // Reset bit set from idle starts a soft reset; other bits ignored
    assign srst_start = wr_ctrl && phy_access_command_reg.data[CTL_SOFT_RESET] && !ctrl_r[CTL_SOFT_RESET];
    // Only writable decoded indices reach the store
    assign mem_we = take && phy_access_command_reg.write
        && WRITABLE_MASK[phy_access_command_reg.index];

    // ==========================================================
    // Basic control register
    // ==========================================================
    // Strap level sets speed and negotiation defaults
    always_comb begin
        ctrl_default = CTL_RESET;
        ctrl_default[CTL_SPEED_100] = speed_strap;
        ctrl_default[CTL_AN_ENABLE] = speed_strap;
    end

    // Soft reset runs a fixed number of cycles
    assign srst_last = ctrl_r[CTL_SOFT_RESET] && (srst_cnt_r == 16'(SOFT_RESET_CYCLES - 1));

    // Control next value: soft reset, host write, restart consume
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_r[CTL_SOFT_RESET]) begin
            // Writes during soft reset are ignored
            if (srst_last) begin
                ctrl_nxt[CTL_SOFT_RESET] = 1'b0;
            end
        end else if (srst_start) begin
            // Fields return to defaults, reset bit reads one
            ctrl_nxt = ctrl_default;
            ctrl_nxt[CTL_SOFT_RESET] = 1'b1;
        end else if (wr_ctrl) begin
            // Reserved bits masked off
            ctrl_nxt = phy_access_command_reg.data & CTL_WRITE_MASK;
        end else if (ctrl_r[CTL_AN_RESTART]) begin
            // Restart bit is consumed by the negotiation machine
            ctrl_nxt[CTL_AN_RESTART] = 1'b0;
        end
    end

    // Soft reset counter
    always_comb begin
        srst_cnt_nxt = 16'h0000;
        if (ctrl_r[CTL_SOFT_RESET] && !srst_last) begin
            srst_cnt_nxt = srst_cnt_r + 16'h0001;
        end
    end

    // Control and counter flops; strap caught during the reset cycles
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r <= ctrl_default;
            srst_cnt_r <= 16'h0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    // ==========================================================
    // Auto-negotiation process
    // ==========================================================
    // Held off by soft reset, power down or disable
    assign an_allowed = ctrl_r[CTL_AN_ENABLE] && !ctrl_r[CTL_POWER_DOWN]
        && !ctrl_r[CTL_SOFT_RESET];
    assign an_last = (an_cnt_r == 32'(AN_CYCLES - 1));

    // Negotiation state machine
    always_comb begin
        an_state_nxt = an_state_r;
        an_cnt_nxt = an_cnt_r;
        if (!an_allowed) begin
            // Disabled: not complete, restart on re-enable
            an_state_nxt = AN_IDLE;
            an_cnt_nxt = 32'h0000_0000;
        end else if (ctrl_r[CTL_AN_RESTART]) begin
            // Host restart begins a fresh process
            an_state_nxt = AN_RUN;
            an_cnt_nxt = 32'h0000_0000;
        end else begin
            case (an_state_r)
                AN_IDLE: begin
                    // Power down cleared or enable set: begin again
                    an_state_nxt = AN_RUN;
                    an_cnt_nxt = 32'h0000_0000;
                end
                AN_RUN: begin
                    if (an_last) begin
                        an_state_nxt = AN_DONE;
                    end else begin
                        an_cnt_nxt = an_cnt_r + 32'h0000_0001;
                    end
                end
                AN_DONE: begin
                    an_state_nxt = AN_DONE;
                end
                default: begin
                    an_state_nxt = AN_IDLE;
                    an_cnt_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Negotiation flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            an_state_r <= AN_IDLE;
            an_cnt_r <= 32'h0000_0000;
        end else begin
            an_state_r <= an_state_nxt;
            an_cnt_r <= an_cnt_nxt;
        end
    end

    // ==========================================================
    // Operating mode outputs
    // ==========================================================
    // Link is up after negotiation, or at once in forced mode
    assign link_up = !ctrl_r[CTL_POWER_DOWN] && !ctrl_r[CTL_SOFT_RESET]
        && (ctrl_r[CTL_AN_ENABLE] ? (an_state_r == AN_DONE) : 1'b1);

    // Forced speed and duplex only count with negotiation off
    always_comb begin
        mode_nxt.loopback = ctrl_r[CTL_LOOPBACK];
        mode_nxt.power_down = ctrl_r[CTL_POWER_DOWN];
        mode_nxt.col_test = ctrl_r[CTL_COL_TEST];
        mode_nxt.an_complete = (an_state_r == AN_DONE);
        mode_nxt.soft_reset = ctrl_r[CTL_SOFT_RESET];
        if (ctrl_r[CTL_AN_ENABLE]) begin
            // Negotiated result: speed 100 and full duplex once complete
            mode_nxt.speed_100 = (an_state_r == AN_DONE);
            mode_nxt.full_duplex = (an_state_r == AN_DONE);
        end else begin
            mode_nxt.speed_100 = ctrl_r[CTL_SPEED_100];
            mode_nxt.full_duplex = ctrl_r[CTL_FULL_DUPLEX];
        end
    end

    // Mode register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_r <= '0;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ==========================================================
    // General register store
    // ==========================================================
    phy_reg_store #(
        .DEPTH(DEPTH),
        .WIDTH(DATA_W),
        .WRITABLE(WRITABLE_MASK),
        .KEEP(KEEP_MASK)
    ) u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .soft_clear(srst_start),
        .wr_en(mem_we),
        .wr_addr(phy_access_command_reg.index),
        .wr_data(phy_access_command_reg.data),
        .rd_addr(phy_access_command_reg.index),
        .rd_data_r(mem_rd)
    );

    // ==========================================================
    // Read path
    // ==========================================================
    // Basic status: fixed abilities plus live completion and link
    always_comb begin
        status_word = STS_CAPS;
        status_word[STS_AN_DONE] = (an_state_r == AN_DONE);
        status_word[STS_LINK] = link_up;
    end

    // Index select; unmapped indices read zero
    always_comb begin
        read_word = 16'h0000;
        if (idx_q_r == IDX_PHY_BASIC_CONTROL) begin
            read_word = ctrl_r & CTL_WRITE_MASK;
        end else if (idx_q_r == IDX_PHY_BASIC_STATUS) begin
            read_word = status_word;
        end else if (idx_q_r == IDX_PHY_IDENT_HIGH) begin
            read_word = IDENT_HIGH;
        end else if (idx_q_r == IDX_PHY_IDENT_LOW) begin
            read_word = IDENT_LOW;
        end else if (DECODED_MASK[idx_q_r]) begin
            read_word = mem_rd;
        end
    end

    // Busy from acceptance until the answer
    always_comb begin
        busy_nxt = busy_r;
        if (take) begin
            busy_nxt = 1'b1;
        end else if (pend_r) begin
            busy_nxt = 1'b0;
        end
    end

    // Stage one: remember command kind and index
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            write_q_r <= 1'b0;
            idx_q_r <= 5'h00;
            busy_r <= 1'b0;
        end else begin
            pend_r <= take;
            write_q_r <= phy_access_command_reg.write;
            idx_q_r <= phy_access_command_reg.index;
            busy_r <= busy_nxt;
        end
    end

    // Stage two: answer pulse with read data
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            access_resp_r <= '0;
        end else begin
            access_resp_r.done <= pend_r;
            access_resp_r.data <= (pend_r && !write_q_r) ? read_word : 16'h0000;
        end
    end

endmodule
`default_nettype wire

// [dv/phy_basic_control_regs_monitor.sv]
// Checker for the PHY register bank access port and mode outputs
`timescale 1ns/1ps
`default_nettype none
module phy_regs_monitor (
    // Clock, reset and strap
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic speed_strap,
    // Indexed access port
    input wire phy_regs_pkg::access_cmd_t phy_access_command_reg,
    input wire phy_regs_pkg::access_resp_t access_resp_r,
    input wire logic busy_r,
    // Mode outputs
    input wire phy_regs_pkg::phy_mode_t mode_r
);
    import phy_regs_pkg::*;
    // ====================================
    // Helpers
    // ====================================
    wire logic acc = phy_access_command_reg.valid && !busy_r;  // Command taken
    wire logic acc_rd = acc && !phy_access_command_reg.write;  // Read taken
    wire logic acc_wr0 = acc && phy_access_command_reg.write && phy_access_command_reg.index == 5'h00;
    wire logic [15:0] wd = phy_access_command_reg.data;  // Write data
    wire logic ctl_wr = acc_wr0 && !wd[15] && !mode_r.soft_reset;  // Plain control write
    wire logic sr_wr = acc_wr0 && wd[15] && !mode_r.soft_reset;  // Soft reset request
    logic [8:0] sr_cnt_r;  // Cycles in soft reset
    logic [8:0] sr_cnt_nxt;
    logic [15:0] wd_p1_r;  // Write data, one cycle old
    logic [15:0] wd_p2_r;  // Write data, two cycles old
    assign sr_cnt_nxt = mode_r.soft_reset ? sr_cnt_r + 9'h001 : 9'h000;
    // Soft reset length counter and data pipe
    always_ff @(posedge core_clk) begin
        sr_cnt_r <= rst_n ? sr_cnt_nxt : 9'h000;
        wd_p1_r <= wd;
        wd_p2_r <= wd_p1_r;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Busy for one cycle, then the answer
    sequence answer_s;
        ##1 busy_r ##1 (access_resp_r.done && !busy_r);
    endsequence
    // ====================================
    // Assertions
    // ====================================
    chk_answer_time: assert property (acc |-> answer_s)
        else $error("answer not two cycles after command");
    chk_write_zero: assert property (acc && phy_access_command_reg.write |-> ##2 access_resp_r.data == 16'h0000)
        else $error("write answer carries data");
    chk_reserved_zero: assert property (acc_rd && phy_access_command_reg.index == 5'h00
        |-> ##2 (access_resp_r.data & 16'h047F) == 16'h0000)
        else $error("reserved control bits read nonzero");
    chk_unmapped_zero: assert property (acc_rd && !DECODED_MASK[phy_access_command_reg.index]
        |-> ##2 access_resp_r.data == 16'h0000)
        else $error("unmapped index read nonzero");
    chk_mode_follow: assert property (ctl_wr |-> ##2 mode_r.loopback == wd_p2_r[14]
        && mode_r.power_down == wd_p2_r[11] && mode_r.col_test == wd_p2_r[7])
        else $error("mode does not follow control write");
    chk_forced_mode: assert property (ctl_wr && !wd[12] |-> ##2 mode_r.speed_100 == wd_p2_r[13]
        && mode_r.full_duplex == wd_p2_r[8])
        else $error("forced speed or duplex wrong");
    chk_soft_hold: assert property (sr_wr |-> ##2 mode_r.soft_reset [*8])
        else $error("soft reset not held");
    chk_soft_length: assert property ($fell(mode_r.soft_reset) |-> sr_cnt_r == 9'(SOFT_RESET_CYCLES))
        else $error("soft reset length wrong");
    chk_soft_defaults: assert property ($fell(mode_r.soft_reset) && !speed_strap |-> mode_r[6:2] == 5'h00)
        else $error("control not at defaults after soft reset");
    chk_power_idle: assert property (mode_r.power_down [*3] |-> !mode_r.an_complete)
        else $error("negotiation complete while powered down");
endmodule
bind phy_basic_control_regs phy_regs_monitor mon_u (.core_clk(core_clk), .rst_n(rst_n), .speed_strap(speed_strap),
    .phy_access_command_reg(phy_access_command_reg), .access_resp_r(access_resp_r), .busy_r(busy_r), .mode_r(mode_r));
`default_nettype wire

// [dv/mac_access_model.sv]
// Host-driven model of the MAC-side indexed access logic
`timescale 1ns/1ps
`default_nettype none
module mac_access_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Command out, answer in
    output var phy_regs_pkg::access_cmd_t cmd_r,
    input wire phy_regs_pkg::access_resp_t resp_r
);
    import phy_regs_pkg::*;
    // Idle command from time zero
    initial cmd_r = '0;
    // One indexed access after gap idle cycles
    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] d, input int gap,
                          output logic [15:0] rd);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        rd = 16'hXXXX;
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        cmd_r <= '{valid: 1'b1, write: wr, index: idx, data: d};
        @(posedge core_clk);
        cmd_r <= '{valid: 1'b0, write: !wr, index: ~idx, data: ~d};  // Released lines flip
        // Bounded wait for the answer
        while (!got && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
            if (resp_r.done === 1'b1) begin
                got = 1'b1;
                rd = resp_r.data;
            end
        end
    endtask
endmodule
`default_nettype wire

// [dv/phy_basic_control_regs_tb.sv]
// Self-checking bench for the PHY register bank
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_regs_tb;
    import phy_regs_pkg::*;
    // ====================================
    // Clock, reset and design
    // ====================================
    localparam int AN_SIM = 20;  // Short negotiation
    localparam logic [15:0] ID_HI = 16'hA5C3;  // Arbitrary identifier value
    localparam logic [15:0] ID_LO = 16'h3C5A;  // Arbitrary identifier value
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic speed_strap = 1'b0;
    access_cmd_t cmd;
    access_resp_t resp;
    logic busy;
    phy_mode_t mode;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] rng_r = 32'h0000_0026;  // Fixed seed
    logic [15:0] mem [32];  // Expected register contents
    logic [15:0] rd;
    always #2.5 core_clk = ~core_clk;
    phy_basic_control_regs #(.AN_CYCLES(AN_SIM), .IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .speed_strap(speed_strap),
        .phy_access_command_reg(cmd), .access_resp_r(resp), .busy_r(busy), .mode_r(mode));
    mac_access_model mac_u (.core_clk(core_clk), .rst_n(rst_n), .cmd_r(cmd), .resp_r(resp));
    // ====================================
    // Helpers
    // ====================================
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    // Entries the host may write
    function automatic logic writable(input logic [4:0] i);
        writable = i inside {5'd4, 5'd17, 5'd18, 5'd27, 5'd30, 5'd31};
    endfunction
    // Mode outputs for a forced-mode control word
    function automatic logic [6:0] mode_of(input logic [15:0] c);
        mode_of = {c[14], c[11], c[13], c[8], c[7], 2'b00};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        mac_u.access(1'b1, i, d, 0, rd);
        check(rd, 16'h0000);
    endtask
    task automatic rd_chk(input logic [4:0] i, input logic [15:0] m, input logic [15:0] e);
        mac_u.access(1'b0, i, 16'h0000, 0, rd);
        check(rd & m, e);
    endtask
    // Reset held 16 cycles, expected contents rebuilt
    task automatic hard_reset();
        int i;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 32; i++) mem[i] = 16'h0000;
        mem[0] = {2'b00, speed_strap, speed_strap, 12'h000};
        mem[1] = 16'h780D;
        mem[2] = ID_HI;
        mem[3] = ID_LO;
        mem[4] = 16'h01E1;
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #(5 * 20000);
        fail_count++;
        finish_test();
    end
    // ====================================
    // Scenarios
    // ====================================
    initial begin
        int i;
        logic [4:0] idx;
        logic [15:0] d;
        hard_reset();
        for (i = 0; i < 32; i++) rd_chk(5'(i), 16'hFFFF, mem[i]);
        // Random writes to store, read-only and unmapped places
        for (i = 0; i < 60; i++) begin
            rng_r = xorshift(rng_r);
            idx = (rng_r[20:16] < 5'd2) ? 5'd30 : rng_r[20:16];
            mac_u.access(1'b1, idx, rng_r[15:0], int'(rng_r[23:22]), rd);
            if (writable(idx)) mem[idx] = rng_r[15:0];
            rd_chk(idx, 16'hFFFF, mem[idx]);
        end
        // Random forced-mode control words
        for (i = 0; i < 12; i++) begin
            rng_r = xorshift(rng_r);
            d = rng_r[15:0] & 16'h6FFF;
            wr(5'd0, d);
            check(16'(mode), 16'(mode_of(d)));
            rd_chk(5'd0, 16'hFFFF, d & 16'h6980);
        end
        // Negotiation, restart and power down
        wr(5'd0, 16'h1000);
        repeat (AN_SIM + 10) @(posedge core_clk);
        rd_chk(5'd1, 16'h0020, 16'h0020);
        check(16'({mode.speed_100, mode.full_duplex}), 16'h0003);
        wr(5'd0, 16'h1200);
        rd_chk(5'd0, 16'h0200, 16'h0000);
        rd_chk(5'd1, 16'h0020, 16'h0000);
        repeat (AN_SIM + 10) @(posedge core_clk);
        rd_chk(5'd1, 16'h0020, 16'h0020);
        wr(5'd0, 16'h1800);
        rd_chk(5'd1, 16'h0020, 16'h0000);
        wr(5'd0, 16'h1000);
        repeat (AN_SIM + 10) @(posedge core_clk);
        rd_chk(5'd1, 16'h0020, 16'h0020);
        // Soft reset written alone, kept and cleared entries
        wr(5'd18, 16'h00A5);
        wr(5'd30, 16'h005A);
        wr(5'd0, 16'h8000);
        rd_chk(5'd0, 16'hFFFF, 16'h8000);
        wr(5'd0, 16'h4000);
        repeat (SOFT_RESET_CYCLES) @(posedge core_clk);
        rd_chk(5'd0, 16'hFFFF, 16'h0000);
        rd_chk(5'd18, 16'hFFFF, 16'h00A5);
        rd_chk(5'd30, 16'hFFFF, 16'h0000);
        // Hard reset with the strap high
        @(posedge core_clk);
        speed_strap <= 1'b1;
        hard_reset();
        rd_chk(5'd0, 16'hFFFF, 16'h3000);
        rd_chk(5'd18, 16'hFFFF, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
